// file: inc/tcc_defines.svh
`ifndef TCC_DEFINES_SVH
`define TCC_DEFINES_SVH

// ==========================================================================
// Sizes.
`define TCC_NCH        12
`define TCC_CH_UNIT    6
`define TCC_NUNIT      2
`define TCC_CTL_W      8
`define TCC_SEL_W      4
`define TCC_CNT_W      16
`define TCC_PS_W       12
`define TCC_NDIV       7
`define TCC_NEXT       4
`define TCC_NPIN       12

// ==========================================================================
// Count control register fields and reset value.
`define TCC_CCLR_HI    7
`define TCC_CCLR_LO    5
`define TCC_CKEG_HI    4
`define TCC_CKEG_LO    3
`define TCC_TPSC_HI    2
`define TCC_TPSC_LO    0
`define TCC_RSV_BIT    7
`define TCC_CTL_RST    8'h00
`define TCC_MASK_FOUR  8'hFF
`define TCC_MASK_TWO   8'h7F

// ==========================================================================
// Clock source selector encoding.
`define TCC_SRC_EXT_BIT 3
`define TCC_SRC_CAS     4'h8
`define TCC_SRC_EXT_A   4'hC

// ==========================================================================
// Pin numbering of the capture/compare pins.
`define TCC_PIN_CH7    0
`define TCC_PIN_CH8    2
`define TCC_PIN_CH9    4
`define TCC_PIN_CH9C   6
`define TCC_PIN_CH9D   7
`define TCC_PIN_CH10   8
`define TCC_PIN_CH11   10
`define TCC_PIN_NONE   -1

`endif

// file: inc/tcc_pkg.sv
package tcc_pkg;

  // Decoded counter clearing source.
  typedef enum logic [2:0] {
    CLR_NONE,
    CLR_A,
    CLR_B,
    CLR_C,
    CLR_D,
    CLR_SYNC
  } tcc_clr_t;

  // Decoded count clock source.
  typedef logic [3:0] tcc_src_t;

endpackage

// file: src/tcc_ctl_bank.sv
`timescale 1ns/100ps
`include "tcc_defines.svh"

module tcc_ctl_bank
  import tcc_pkg::*;
(
  // Clock and reset.
  input  wire logic                                clk,
  input  wire logic                                rst_n,
  // Access port.
  input  wire logic                                wr,
  input  wire logic                                rd,
  input  wire logic [`TCC_SEL_W-1:0]               sel,
  input  wire logic [`TCC_CTL_W-1:0]               wdata,
  output logic      [`TCC_CTL_W-1:0]               rdata,
  // All control registers side by side.
  output logic      [`TCC_NCH*`TCC_CTL_W-1:0]      ctl_flat
);

  logic [`TCC_CTL_W-1:0] ctl_reg [`TCC_NCH];
  logic [`TCC_CTL_W-1:0] rdata_reg;
  logic [`TCC_CTL_W-1:0] rdata_next;
  wire                   sel_ok = (sel < `TCC_SEL_W'(`TCC_NCH));

  // ========================================================================
  // One register per channel.
  genvar ch;
  generate
    for (ch = 0; ch < `TCC_NCH; ch++) begin : g_ctl
      localparam int M = ch % `TCC_CH_UNIT;
      localparam logic [`TCC_CTL_W-1:0] MASK =
        (M == 0 || M == 3) ? `TCC_MASK_FOUR : `TCC_MASK_TWO;
      wire hit = wr && sel == `TCC_SEL_W'(ch);
      always_ff @(posedge clk) begin
        if (!rst_n) begin
          ctl_reg[ch] <= `TCC_CTL_RST;
        end else if (hit) begin
          ctl_reg[ch] <= wdata & MASK;
        end
      end
      assign ctl_flat[ch*`TCC_CTL_W +: `TCC_CTL_W] = ctl_reg[ch];
    end
  endgenerate

  // ========================================================================
  // Registered read port; unused selector values read as zero.
  assign rdata_next = rd ? (sel_ok ? ctl_reg[sel] : `TCC_CTL_RST) : rdata_reg;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rdata_reg <= `TCC_CTL_RST;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  assign rdata = rdata_reg;

endmodule

// file: src/tcc_top.sv
`timescale 1ns/100ps
`include "tcc_defines.svh"

// Notes on behaviour
// - Twelve independent count control registers, one per channel across both units.
// - Four-register channels: 000/100 none, 001 A, 010 B, 101 C, 110 D.
// - Codes 011 and 111 clear on another lockstep channel's counter clear.
// - A channel joins lockstep clearing only when its lockstep bit is set.
// - C or D acting as buffer never clears the counter.
// - Two-register channels: 00 none, 01 A, 10 B, 11 lockstep clear.
// - On two-register channels bit 7 reads zero and ignores writes.
// - Both-edge selection counts rising and falling edges, halving the period.
// - While phase counting is active the edge field is ignored.
// - Internal edge choice applies from divide-by-4; undivided clock ignores it.
// - Cascaded overflow source ignores the edge field.
// - Each channel picks its own clock source through its three-bit field.
// - Both units share identical count control behaviour.
// - Channel 9 has four two-way pins, one per general register.
// - Channels 7, 8, 10, 11 have two two-way pins for A and B.
// - Edge code 00 internal falling/external rising, 01 reverse, 1x both.
// - Channels 0 and 6: codes 0-3 divide by 1/4/16/64, 4-7 external A-D.
module tcc_top
  import tcc_pkg::*;
(
  // Clock and reset.
  input  wire logic                               MCLK,
  input  wire logic                               RST_N,
  // Control register port.
  input  wire logic                               REG_WR,
  input  wire logic                               REG_RD,
  input  wire logic [`TCC_SEL_W-1:0]              REG_SEL,
  input  wire logic [`TCC_CTL_W-1:0]              REG_WDATA,
  output logic      [`TCC_CTL_W-1:0]              REG_RDATA,
  // Common run and lockstep bits, one per channel.
  input  wire logic [`TCC_NCH-1:0]                CH_RUN,
  input  wire logic [`TCC_NCH-1:0]                CH_LOCKSTEP,
  // Mode inputs from the mode registers.
  input  wire logic [`TCC_NCH-1:0]                BUF_C_MODE,
  input  wire logic [`TCC_NCH-1:0]                BUF_D_MODE,
  input  wire logic [`TCC_NCH-1:0]                PHASE_MODE,
  input  wire logic [`TCC_NCH-1:0]                PHASE_TICK,
  // Match or capture events of the general registers.
  input  wire logic [`TCC_NCH-1:0]                EVT_A,
  input  wire logic [`TCC_NCH-1:0]                EVT_B,
  input  wire logic [`TCC_NCH-1:0]                EVT_C,
  input  wire logic [`TCC_NCH-1:0]                EVT_D,
  // External count inputs, A to D of unit 0 then unit 1.
  input  wire logic [`TCC_NUNIT*`TCC_NEXT-1:0]    EXT_CLK,
  // Capture/compare pins.
  input  wire logic [`TCC_NPIN-1:0]               PIN_IN,
  input  wire logic [`TCC_NPIN-1:0]               PIN_LEVEL,
  input  wire logic [`TCC_NPIN-1:0]               PIN_DRIVE,
  output logic      [`TCC_NPIN-1:0]               PIN_OUT,
  output logic      [`TCC_NPIN-1:0]               PIN_OE,
  // Counters and overflow pulses.
  output logic      [`TCC_NCH*`TCC_CNT_W-1:0]     COUNT,
  output logic      [`TCC_NCH-1:0]                OVERFLOW
);

  // ========================================================================
  // Decoders shared by every channel.
  function automatic tcc_src_t src_decode(input int m, input logic [2:0] code);
    tcc_src_t s;
    s = {1'b0, code};
    if (code[2]) begin
      case (m)
        0: s = `TCC_SRC_EXT_A + {2'h0, code[1:0]};
        1: s = (code == 3'h4) ? `TCC_SRC_EXT_A : (code == 3'h5) ? `TCC_SRC_EXT_A + 4'h1 :
               (code == 3'h6) ? 4'h4 : `TCC_SRC_CAS;
        2: s = (code == 3'h7) ? 4'h5 : `TCC_SRC_EXT_A + {2'h0, code[1:0]};
        3: s = (code == 3'h4) ? `TCC_SRC_EXT_A : (code == 3'h5) ? 4'h5 :
               (code == 3'h6) ? 4'h4 : 4'h6;
        4: s = (code == 3'h4) ? `TCC_SRC_EXT_A : (code == 3'h5) ? `TCC_SRC_EXT_A + 4'h2 :
               (code == 3'h6) ? 4'h5 : `TCC_SRC_CAS;
        default: s = (code == 3'h4) ? `TCC_SRC_EXT_A : (code == 3'h5) ? `TCC_SRC_EXT_A + 4'h2 :
               (code == 3'h6) ? 4'h4 : `TCC_SRC_EXT_A + 4'h3;
      endcase
    end
    return s;
  endfunction

  function automatic tcc_clr_t clr_decode(input logic four, input logic [2:0] code);
    tcc_clr_t c;
    c = CLR_NONE;
    case (code[1:0])
      2'h1: c = (four && code[2]) ? CLR_C : CLR_A;
      2'h2: c = (four && code[2]) ? CLR_D : CLR_B;
      2'h3: c = CLR_SYNC;
      default: c = CLR_NONE;
    endcase
    return c;
  endfunction

  function automatic int pin_base(input int ch);
    case (ch)
      7: return `TCC_PIN_CH7;
      8: return `TCC_PIN_CH8;
      9: return `TCC_PIN_CH9;
      10: return `TCC_PIN_CH10;
      11: return `TCC_PIN_CH11;
      default: return `TCC_PIN_NONE;
    endcase
  endfunction

  // ========================================================================
  // Control registers.
  logic [`TCC_NCH*`TCC_CTL_W-1:0] ctl_flat;

  tcc_ctl_bank u_bank (
    .clk      (MCLK),
    .rst_n    (RST_N),
    .wr       (REG_WR),
    .rd       (REG_RD),
    .sel      (REG_SEL),
    .wdata    (REG_WDATA),
    .rdata    (REG_RDATA),
    .ctl_flat (ctl_flat)
  );

  // ========================================================================
  // Free prescaler and edge sampling. Everything stays on MCLK, so the
  // slow clocks are one-cycle enables and no derived clock exists.
  logic [`TCC_PS_W-1:0]               ps_reg;
  logic [`TCC_PS_W-1:0]               ps_prev_reg;
  logic [`TCC_NUNIT*`TCC_NEXT-1:0]    ext_prev_reg;
  logic [`TCC_NPIN-1:0]               pin_prev_reg;
  logic [`TCC_NDIV-1:0]               div_rise;
  logic [`TCC_NDIV-1:0]               div_fall;
  wire  [`TCC_NUNIT*`TCC_NEXT-1:0]    ext_rise = EXT_CLK & ~ext_prev_reg;
  wire  [`TCC_NUNIT*`TCC_NEXT-1:0]    ext_fall = ~EXT_CLK & ext_prev_reg;
  wire  [`TCC_NPIN-1:0]               pin_cap  = PIN_IN & ~pin_prev_reg & ~PIN_OE;

  assign div_rise[0] = 1'b1;
  assign div_fall[0] = 1'b1;

  genvar k;
  generate
    for (k = 1; k < `TCC_NDIV; k++) begin : g_div
      assign div_rise[k] = ps_reg[2*k-1] & ~ps_prev_reg[2*k-1];
      assign div_fall[k] = ~ps_reg[2*k-1] & ps_prev_reg[2*k-1];
    end
  endgenerate

  // Edge history follows the inputs through reset, so release shows no false edge.
  always_ff @(posedge MCLK) begin
    ext_prev_reg <= EXT_CLK;
    pin_prev_reg <= PIN_IN;
    if (!RST_N) begin
      ps_reg       <= '0;
      ps_prev_reg  <= '0;
      PIN_OUT      <= '0;
      PIN_OE       <= '0;
    end else begin
      ps_reg       <= ps_reg + `TCC_PS_W'(1);
      ps_prev_reg  <= ps_reg;
      PIN_OUT      <= PIN_LEVEL;
      PIN_OE       <= PIN_DRIVE;
    end
  end

  // ========================================================================
  // Lockstep clearing: any lockstep channel that clears itself clears
  // every lockstep channel of its unit that selected the lockstep code.
  logic [`TCC_NCH-1:0]   sync_req;
  logic [`TCC_NUNIT-1:0] unit_sync;

  genvar u;
  generate
    for (u = 0; u < `TCC_NUNIT; u++) begin : g_unit
      assign unit_sync[u] = |sync_req[u*`TCC_CH_UNIT +: `TCC_CH_UNIT];
    end
  endgenerate

  // ========================================================================
  // Channels.
  genvar ch;
  generate
    for (ch = 0; ch < `TCC_NCH; ch++) begin : g_ch
      localparam int   U    = ch / `TCC_CH_UNIT;
      localparam int   M    = ch % `TCC_CH_UNIT;
      localparam logic FOUR = (M == 0 || M == 3);
      localparam int   CAS  = (M == 1 || M == 4) ? ch + 1 : ch;
      localparam int   PB   = pin_base(ch);

      logic [`TCC_CNT_W-1:0] cnt_reg;
      logic [`TCC_CNT_W-1:0] cnt_next;
      logic                  ovf_reg;
      logic                  ovf_next;
      logic                  pa;
      logic                  pb;
      logic                  pc;
      logic                  pd;

      wire [`TCC_CTL_W-1:0] ctl  = ctl_flat[ch*`TCC_CTL_W +: `TCC_CTL_W];
      wire [2:0]            cclr = ctl[`TCC_CCLR_HI:`TCC_CCLR_LO];
      wire [1:0]            ckeg = ctl[`TCC_CKEG_HI:`TCC_CKEG_LO];
      wire tcc_src_t        src  = src_decode(M, ctl[`TCC_TPSC_HI:`TCC_TPSC_LO]);
      wire tcc_clr_t        clr  = clr_decode(FOUR, cclr);
      wire [2:0]            dv   = src[2:0];
      wire [1:0]            ei   = src[1:0];

      // Edge choice; the undivided clock counts every cycle regardless.
      wire tick_int = (dv == 3'h0) ? 1'b1 :
                      ckeg[1] ? (div_rise[dv] | div_fall[dv]) :
                      ckeg[0] ? div_rise[dv] : div_fall[dv];
      wire er = ext_rise[U*`TCC_NEXT + int'(ei)];
      wire ef = ext_fall[U*`TCC_NEXT + int'(ei)];
      wire tick_ext = ckeg[1] ? (er | ef) : ckeg[0] ? ef : er;
      wire is_ext   = src[`TCC_SRC_EXT_BIT] && src != `TCC_SRC_CAS;
      wire tick_src = (src == `TCC_SRC_CAS) ? OVERFLOW[CAS] :
                      is_ext ? tick_ext : tick_int;
      wire phase_on = PHASE_MODE[ch] & ~FOUR;
      wire tick     = phase_on ? PHASE_TICK[ch] : tick_src;
      wire cnt_en   = CH_RUN[ch] & tick;

      if (PB >= 0) begin : g_pin_ab
        assign pa = pin_cap[PB];
        assign pb = pin_cap[PB+1];
      end else begin : g_no_ab
        assign pa = 1'b0;
        assign pb = 1'b0;
      end
      if (ch == 9) begin : g_pin_cd
        assign pc = pin_cap[`TCC_PIN_CH9C];
        assign pd = pin_cap[`TCC_PIN_CH9D];
      end else begin : g_no_cd
        assign pc = 1'b0;
        assign pd = 1'b0;
      end

      // A register used as a buffer raises no event, so it cannot clear.
      wire ev_a = EVT_A[ch] | pa;
      wire ev_b = EVT_B[ch] | pb;
      wire ev_c = FOUR & (EVT_C[ch] | pc) & ~BUF_C_MODE[ch];
      wire ev_d = FOUR & (EVT_D[ch] | pd) & ~BUF_D_MODE[ch];
      wire own_clr = (clr == CLR_A && ev_a) || (clr == CLR_B && ev_b) ||
                     (clr == CLR_C && ev_c) || (clr == CLR_D && ev_d);
      wire clr_now = own_clr ||
                     (clr == CLR_SYNC && CH_LOCKSTEP[ch] && unit_sync[U]);

      assign sync_req[ch] = own_clr & CH_LOCKSTEP[ch];
      assign cnt_next = clr_now ? '0 : cnt_en ? cnt_reg + `TCC_CNT_W'(1) : cnt_reg;
      assign ovf_next = cnt_en && !clr_now && (&cnt_reg);

      always_ff @(posedge MCLK) begin
        if (!RST_N) begin
          cnt_reg <= '0;
          ovf_reg <= 1'b0;
        end else begin
          cnt_reg <= cnt_next;
          ovf_reg <= ovf_next;
        end
      end

      assign COUNT[ch*`TCC_CNT_W +: `TCC_CNT_W] = cnt_reg;
      assign OVERFLOW[ch] = ovf_reg;
    end
  endgenerate

endmodule

// file: verification/tcc_top_sva.sv
`timescale 1ns/100ps
`include "tcc_defines.svh"

module tcc_top_sva
  import tcc_pkg::*;
(
  // Clock and reset.
  input wire logic                           MCLK,
  input wire logic                           RST_N,
  // Register port.
  input wire logic                           REG_WR,
  input wire logic                           REG_RD,
  input wire logic [`TCC_SEL_W-1:0]          REG_SEL,
  input wire logic [`TCC_CTL_W-1:0]          REG_WDATA,
  input wire logic [`TCC_CTL_W-1:0]          REG_RDATA,
  // Channel controls and results.
  input wire logic [`TCC_NCH-1:0]            CH_RUN,
  input wire logic [`TCC_NCH-1:0]            EVT_A,
  input wire logic [`TCC_NPIN-1:0]           PIN_LEVEL,
  input wire logic [`TCC_NPIN-1:0]           PIN_DRIVE,
  input wire logic [`TCC_NPIN-1:0]           PIN_OUT,
  input wire logic [`TCC_NPIN-1:0]           PIN_OE,
  input wire logic [`TCC_NCH*`TCC_CNT_W-1:0] COUNT,
  input wire logic [`TCC_NCH-1:0]            OVERFLOW
);
  // ==========================================================================
  // Shadow of channel 0 control, so counting rules can be tied to the setting.
  logic [`TCC_CTL_W-1:0] ctl0_reg;
  logic [15:0]           c0;
  assign c0 = COUNT[15:0];
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      ctl0_reg <= `TCC_CTL_RST;
    end else if (REG_WR && REG_SEL == 4'h0) begin
      ctl0_reg <= REG_WDATA;
    end
  end
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RST_N);

  a_unmapped_read: assert property (REG_RD && REG_SEL >= 4'hC |=> REG_RDATA == 8'h00)
    else $error("unmapped read returned nonzero data");
  a_rdata_holds: assert property (!REG_RD |=> $stable(REG_RDATA))
    else $error("read data changed without a read");
  a_two_reg_bit7: assert property (REG_RD && REG_SEL == 4'h1 |=> !REG_RDATA[7])
    else $error("bit 7 of a two-register channel read as one");
  a_div1_count: assert property (CH_RUN[0] && ctl0_reg[2:0] == 3'h0 && ctl0_reg[6:5] == 2'h0
    |=> c0 == $past(c0) + 16'h0001)
    else $error("undivided clock did not count every cycle");
  a_halt_hold: assert property (!CH_RUN[0] && ctl0_reg[6:5] == 2'h0 |=> $stable(c0))
    else $error("halted counter moved");
  a_clear_on_a: assert property (EVT_A[0] && ctl0_reg[7:5] == 3'b001 |=> c0 == 16'h0000)
    else $error("register A event did not clear the counter");
  a_reset_zero: assert property ($rose(RST_N) |-> COUNT == '0 && REG_RDATA == 8'h00)
    else $error("state not zero after reset");
  a_pin_follow: assert property (RST_N |=> PIN_OUT == $past(PIN_LEVEL)
    && PIN_OE == $past(PIN_DRIVE))
    else $error("pin output or enable did not follow request");
  a_ovf_pulse: assert property (OVERFLOW[0] |=> !OVERFLOW[0])
    else $error("overflow longer than one cycle");
endmodule

bind tcc_top tcc_top_sva chk (.MCLK, .RST_N, .REG_WR, .REG_RD, .REG_SEL, .REG_WDATA,
  .REG_RDATA, .CH_RUN, .EVT_A, .PIN_LEVEL, .PIN_DRIVE, .PIN_OUT, .PIN_OE, .COUNT, .OVERFLOW);

// file: verification/tcc_far_end.sv
`timescale 1ns/100ps
`include "tcc_defines.svh"

module tcc_far_end (
  // Clock.
  input  wire logic                             clk,
  // Capture/compare pins.
  input  wire logic [`TCC_NPIN-1:0]             pin_out,
  input  wire logic [`TCC_NPIN-1:0]             pin_oe,
  output logic      [`TCC_NPIN-1:0]             pin_in,
  // External count sources.
  output logic      [`TCC_NUNIT*`TCC_NEXT-1:0]  ext_clk
);
  // ==========================================================================
  // Pins carry pull-ups, so a released pin reads high rather than a stale level.
  logic [3:0] phase_reg = 4'h0;
  assign pin_in = (pin_out & pin_oe) | ~pin_oe;
  // Sources are set up as buffered inputs and run as square waves of four cycles.
  always @(posedge clk) begin
    #1 phase_reg <= phase_reg + 4'h1;
  end
  assign ext_clk = {8{phase_reg[1]}};
endmodule

// file: verification/tcc_top_tb_top.sv
`timescale 1ns/100ps
`include "tcc_defines.svh"

module tcc_top_tb_top;
  import tcc_pkg::*;
  // ==========================================================================
  // Stimulus and checking.
  logic        MCLK = 1'b0, RST_N = 1'b0, REG_WR = 1'b0, REG_RD = 1'b0;
  logic [3:0]  REG_SEL = '0;
  logic [7:0]  REG_WDATA = '0, REG_RDATA, rd, wd;
  logic [11:0] CH_RUN = '0, CH_LOCKSTEP = '0, BUF_C_MODE = '0, BUF_D_MODE = '0;
  logic [11:0] PHASE_MODE = '0, PHASE_TICK = '0, EVT_A = '0, EVT_B = '0, EVT_C = '0, EVT_D = '0;
  logic [11:0] PIN_IN, PIN_LEVEL = 0, PIN_DRIVE = 0, PIN_OUT, PIN_OE, OVERFLOW;
  logic [7:0]  EXT_CLK;
  logic [191:0] COUNT;
  logic [31:0] lfsr_reg = 32'he173_0529;
  logic [15:0] base [12];
  logic        ov;
  int          err_total = 0, n_compared = 0;
  logic [7:0]  ctl_t [12] = '{8'h00, 8'h08, 8'h01, 8'h09, 8'h11, 8'h02,
                              8'h14, 8'h0D, 8'h16, 8'h00, 8'h04, 8'h17};
  logic [15:0] del_t [12] = '{16'h0010, 16'h0010, 16'h0004, 16'h0004, 16'h0008, 16'h0001,
                              16'h0008, 16'h0004, 16'h0008, 16'h0000, 16'h0004, 16'h0008};

  tcc_top dut (.MCLK, .RST_N, .REG_WR, .REG_RD, .REG_SEL, .REG_WDATA, .REG_RDATA, .CH_RUN,
    .CH_LOCKSTEP, .BUF_C_MODE, .BUF_D_MODE, .PHASE_MODE, .PHASE_TICK, .EVT_A, .EVT_B, .EVT_C,
    .EVT_D, .EXT_CLK, .PIN_IN, .PIN_LEVEL, .PIN_DRIVE, .PIN_OUT, .PIN_OE, .COUNT, .OVERFLOW);
  tcc_far_end far (.clk(MCLK), .pin_out(PIN_OUT), .pin_oe(PIN_OE), .pin_in(PIN_IN),
    .ext_clk(EXT_CLK));

  always #12.5 MCLK = ~MCLK;

  function automatic logic [31:0] lfsr_step(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [15:0] cnt(input int i);
    return COUNT[16*i +: 16];
  endfunction
  function automatic logic [7:0] rd_exp(input logic [3:0] s, input logic [7:0] d);
    if (s >= 4'hC) return 8'h00;
    return (s % 3 == 0) ? d : (d & `TCC_MASK_TWO);
  endfunction
  function automatic bit clr_exp(input logic [2:0] c, input int e, input bit b);
    case (c)
      3'b001: return e == 0;
      3'b010: return e == 1;
      3'b101: return e == 2 && !b;
      3'b110: return e == 3 && !b;
      default: return 0;
    endcase
  endfunction

  task automatic tick(input int n);
    repeat (n) @(posedge MCLK);
    #1;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic reg_wr(input logic [3:0] sel, input logic [7:0] d);
    REG_WR = 1'b1;
    REG_SEL = sel;
    REG_WDATA = d;
    tick(1);
    REG_WR = 1'b0;
    tick(1);
  endtask
  task automatic reg_rd(input logic [3:0] sel, output logic [7:0] d);
    REG_RD = 1'b1;
    REG_SEL = sel;
    tick(1);
    REG_RD = 1'b0;
    tick(1);
    d = REG_RDATA;
  endtask
  task automatic wrap_up;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Pin requests are random every cycle; the checker follows them.
  always @(posedge MCLK) begin
    #1;
    lfsr_reg = lfsr_step(lfsr_reg);
    {PIN_LEVEL, PIN_DRIVE} = lfsr_reg[23:0];
  end

  initial begin
    repeat (80000) @(posedge MCLK);
    err_total++;
    wrap_up();
  end

  initial begin
    tick(4);
    RST_N = 1'b1;
    for (int i = 0; i < 16; i++) begin
      reg_rd(i[3:0], rd);
      chk(rd, 8'h00);
    end
    for (int i = 0; i < 16; i++) begin
      wd = lfsr_reg[7:0] | 8'h80;
      reg_wr(i[3:0], wd);
      reg_rd(i[3:0], rd);
      chk(rd, rd_exp(i[3:0], wd));
    end
    // A window of sixteen cycles is a whole number of every period used here.
    for (int i = 0; i < 12; i++) reg_wr(i[3:0], ctl_t[i]);
    for (int i = 0; i < 12; i++) base[i] = cnt(i);
    CH_RUN = 12'hDFF;
    tick(16);
    CH_RUN = '0;
    for (int i = 0; i < 12; i++) chk(16'(cnt(i) - base[i]), del_t[i]);
    for (int b = 0; b < 2; b++) begin
      BUF_C_MODE = {12{b[0]}};
      BUF_D_MODE = {12{b[0]}};
      for (int c = 0; c < 8; c++) for (int e = 0; e < 4; e++) begin
        reg_wr(4'h0, {c[2:0], 5'h00});
        CH_RUN[0] = 1'b1;
        tick(2);
        {EVT_D[0], EVT_C[0], EVT_B[0], EVT_A[0]} = 4'h1 << e;
        base[0] = cnt(0);
        tick(1);
        {EVT_D[0], EVT_C[0], EVT_B[0], EVT_A[0]} = 4'h0;
        CH_RUN[0] = 1'b0;
        chk(cnt(0), clr_exp(c[2:0], e, b[0]) ? 16'h0000 : 16'(base[0] + 16'h0001));
      end
    end
    reg_wr(4'h0, 8'h20);
    reg_wr(4'h1, 8'h60);
    reg_wr(4'h2, 8'h60);
    // Unit 1: channel 6 clears on A, 11 follows it in lockstep, 10 counts 11's wraps.
    reg_wr(4'h6, 8'h20);
    reg_wr(4'hB, 8'h60);
    reg_wr(4'hA, 8'h1F);
    base[10] = cnt(10);
    CH_LOCKSTEP = 12'h843;
    CH_RUN = 12'hC07;
    tick(3);
    EVT_A[0] = 1'b1;
    EVT_A[6] = 1'b1;
    base[2] = cnt(2);
    tick(1);
    EVT_A[0] = 1'b0;
    EVT_A[6] = 1'b0;
    chk({cnt(0), cnt(1)}, 32'h0000_0000);
    chk(cnt(11), 16'h0000);
    chk(cnt(2), 16'(base[2] + 16'h0001));
    // Phase mode: channel 2 follows its phase tick only, channel 0 ignores the mode.
    PHASE_MODE = 12'h005;
    base[0] = cnt(0);
    base[2] = cnt(2);
    tick(2);
    PHASE_TICK[2] = 1'b1;
    tick(1);
    PHASE_TICK[2] = 1'b0;
    tick(2);
    PHASE_MODE = '0;
    chk(16'(cnt(2) - base[2]), 16'h0001);
    chk(16'(cnt(0) - base[0]), 16'h0005);
    for (int k = 0; k < 70000 && cnt(0) !== 16'hFFFF; k++) tick(1);
    tick(1);
    ov = OVERFLOW[0] & OVERFLOW[11];
    chk(cnt(0), 16'h0000);
    chk(cnt(11), 16'h0000);
    tick(1);
    chk({ov, OVERFLOW[0], OVERFLOW[11]}, 32'h0000_0004);
    chk(cnt(10), 16'(base[10] + 16'h0001));
    tick(1);
    chk(cnt(10), 16'(base[10] + 16'h0001));
    wrap_up();
  end
endmodule
